// [slf_pkg.sv]
// constants, field layout and state type for the segment display frame controller
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
package slf_pkg;

    // register byte addresses
    localparam logic [7:0] CTRL_A_ADDR   = 8'h00;
    localparam logic [7:0] CTRL_B_ADDR   = 8'h04;
    localparam logic [7:0] FRAME_RATE_ADDR = 8'h08;
    localparam logic [7:0] CONTRAST_ADDR = 8'h0c;
    localparam logic [7:0] ASYNC_ADDR    = 8'h10;
    localparam logic [7:0] POWER_ADDR    = 8'h14;
    localparam logic [7:0] STATUS_ADDR   = 8'h18;
    localparam logic [7:0] MEM_BASE_ADDR = 8'h20;
    localparam logic [7:0] MEM_LAST_ADDR = 8'h2c;

    // display_config_a fields
    localparam int EN_BIT    = 7;
    localparam int LPW_BIT   = 6;
    localparam int FLAG_BIT  = 4;
    localparam int IE_BIT    = 3;
    localparam int BLANK_BIT = 0;
    // display_config_b fields
    localparam int CS_BIT    = 7;
    localparam int HALF_BIT  = 6;
    localparam int DUTY_LSB  = 4;
    localparam int PM_LSB    = 0;
    // frame_rate_reg fields
    localparam int PS_LSB    = 4;
    localparam int CD_LSB    = 0;
    // contrast_control_reg fields
    localparam int DT_LSB    = 5;
    localparam int CC_LSB    = 0;
    // async_status_reg and power_reduction_reg fields
    localparam int EXTERNAL_CLOCK_ENABLE_BIT_BIT = 4;
    localparam int PRR_BIT   = 4;

    localparam int SEG_COUNT = 25;
    localparam int COM_COUNT = 4;

    // reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // prescaler: counter bits that must all be one for a prescaled tick
    localparam logic [11:0] PS_MASK [0:7] = '{12'h00f, 12'h03f, 12'h07f, 12'h0ff,
                                              12'h1ff, 12'h3ff, 12'h7ff, 12'hfff};
    // segment terminals kept for display per port mask value
    localparam logic [4:0] PM_SEGS [0:7] = '{5'h0d, 5'h0f, 5'h11, 5'h13,
                                             5'h15, 5'h17, 5'h18, 5'h19};

    // sleep mode codes on the sleep_mode input
    localparam logic [2:0] SLEEP_NONE    = 3'h0;
    localparam logic [2:0] SLEEP_IDLE    = 3'h1;
    localparam logic [2:0] SLEEP_ADC_NR  = 3'h2;
    localparam logic [2:0] SLEEP_PDOWN   = 3'h3;
    localparam logic [2:0] SLEEP_PSAVE   = 3'h4;
    localparam logic [2:0] SLEEP_STANDBY = 3'h5;

    // one drive-time step in cycles of mclk
    localparam logic [11:0] DRIVE_STEP_CYC = 12'h010;

    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_WAIT  = 2'b01,
        ST_RUN   = 2'b11,
        ST_BLANK = 2'b10
    } slf_state_type;

endpackage

// [slf_frame_ctrl.sv]
// segment display frame controller: clock select, prescaler, frame and common scan,
// segment/common phase drive, blanking and port masking, registers on classic wishbone
// assumes timer_osc_input_pin and supply_ready are asynchronous; pad logic outside
// turns phase/address/oe/ground controls into glass voltages
`timescale 1ns/100ps
module slf_frame_ctrl
    import slf_pkg::*;
#(
    parameter logic [11:0] DRIVE_STEP = DRIVE_STEP_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 timer_osc_input_pin,
    input  wire logic                 supply_ready,
    input  wire logic [2:0]           sleep_mode,
    input  wire logic                 sys_clk_is_rc,
    input  wire logic                 frame_flag_ack,
    output logic                      frame_flag,
    output logic [SEG_COUNT-1:0]      segment_terminal_phase,
    output logic [SEG_COUNT-1:0]      segment_terminal_own,
    output logic [COM_COUNT-1:0]      common_terminal_phase,
    output logic [COM_COUNT-1:0]      common_terminal_addr,
    output logic [COM_COUNT-1:0]      common_terminal_own,
    output logic                      pins_oe,
    output logic                      ground_all,
    output logic                      bias_buffer_en,
    output logic [1:0]                bias_mode,
    output logic [3:0]                contrast_level,
    output logic                      ext_clock_buffer_en,
    output logic                      crystal_osc_en
);

    typedef struct packed {
        // software fields
        logic                            en;
        logic                            lpw;
        logic                            flag;
        logic                            ie;
        logic                            blank;
        logic                            cs;
        logic                            half;
        logic [1:0]                      duty;
        logic [2:0]                      pm;
        logic [2:0]                      ps;
        logic [2:0]                      cd;
        logic [2:0]                      dt;
        logic [3:0]                      cc;
        logic                            external_clock_enable_bit;
        logic                            power_reduction_reg;
        logic [COM_COUNT-1:0][SEG_COUNT-1:0] mem;
        // per-frame latched copy
        logic [COM_COUNT-1:0][SEG_COUNT-1:0] lat;
        logic                            lat_lpw;
        logic                            lat_blank;
        logic [3:0]                      lat_cc;
        // synchronisers
        logic                            osc_s1;
        logic                            osc_s2;
        logic                            osc_s3;
        logic                            rdy_s1;
        logic                            rdy_s2;
        // timing
        logic [11:0]                     pre;
        logic [2:0]                      fine;
        logic [1:0]                      com;
        logic                            half_ph;
        logic                            frame_pol;
        logic                            repeat_frame;
        logic [15:0]                     drv_cnt;
        slf_state_type                   state;
        // bus
        logic                            ack;
        logic [31:0]                     dat;
        // outputs
        logic [SEG_COUNT-1:0]            seg_ph;
        logic [SEG_COUNT-1:0]            seg_own;
        logic [COM_COUNT-1:0]            com_ph;
        logic [COM_COUNT-1:0]            com_addr;
        logic [COM_COUNT-1:0]            com_own;
        logic                            oe;
        logic                            gnd;
        logic                            buf_en;
        logic [1:0]                      bias;
        logic                            ext_buf;
        logic                            xtal;
    } slf_regs_type;

    slf_regs_type q;
    slf_regs_type n;

    logic        req;
    logic        wr_commit;
    logic [31:0] wmask;
    logic [31:0] rdata;
    logic [31:0] wv;
    logic        osc_rise;
    logic        active;
    logic        run_ok;
    logic        base_tick;
    logic        ps_tick;
    logic        tick;
    logic        fstart;
    logic        pol;
    logic [4:0]  nseg;

    always_comb begin
        n         = q;
        req       = wb_cyc_i & wb_stb_i;
        wr_commit = req & wb_we_i & q.ack;
        wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        rdata     = 32'h0000_0000;
        wv        = 32'h0000_0000;
        fstart    = 1'b0;

        // first stage feeds only the second
        n.osc_s1 = timer_osc_input_pin;
        n.osc_s2 = q.osc_s1;
        n.osc_s3 = q.osc_s2;
        n.rdy_s1 = supply_ready;
        n.rdy_s2 = q.rdy_s1;
        osc_rise = q.osc_s2 & ~q.osc_s3;

        // bus: ack one cycle after request, write lands on the edge ack is seen
        n.ack = req & ~q.ack;
        if (wb_adr_i == CTRL_A_ADDR) begin
            rdata = {24'h0, q.en, q.lpw, 1'b0, q.flag, q.ie, 2'b00, q.blank};
        end else if (wb_adr_i == CTRL_B_ADDR) begin
            rdata = {24'h0, q.cs, q.half, q.duty, 1'b0, q.pm};
        end else if (wb_adr_i == FRAME_RATE_ADDR) begin
            rdata = {24'h0, 1'b0, q.ps, 1'b0, q.cd};
        end else if (wb_adr_i == CONTRAST_ADDR) begin
            rdata = {24'h0, q.dt, 1'b0, q.cc};
        end else if (wb_adr_i == ASYNC_ADDR) begin
            rdata = {27'h0, q.external_clock_enable_bit, 4'h0};
        end else if (wb_adr_i == POWER_ADDR) begin
            rdata = {27'h0, q.power_reduction_reg, 4'h0};
        end else if (wb_adr_i == STATUS_ADDR) begin
            rdata = {24'h0, q.state, q.com, q.half_ph, q.repeat_frame, q.rdy_s2, q.lat_blank};
        end else if (wb_adr_i >= MEM_BASE_ADDR && wb_adr_i <= MEM_LAST_ADDR && wb_adr_i[1:0] == 2'b00) begin
            rdata = {7'h0, q.mem[wb_adr_i[3:2]]};
        end
        if (req & ~q.ack) begin
            n.dat = rdata;
        end
        wv = (rdata & ~wmask) | (wb_dat_i & wmask);

        if (wr_commit) begin
            if (wb_adr_i == CTRL_A_ADDR) begin
                n.en    = wv[EN_BIT];
                n.lpw   = wv[LPW_BIT];
                n.ie    = wv[IE_BIT];
                n.blank = wv[BLANK_BIT];
                if (wb_sel_i[0] && wb_dat_i[FLAG_BIT]) begin
                    n.flag = 1'b0;
                end
            end else if (wb_adr_i == CTRL_B_ADDR) begin
                n.cs   = wv[CS_BIT];
                n.half = wv[HALF_BIT];
                n.duty = wv[DUTY_LSB+:2];
                n.pm   = wv[PM_LSB+:3];
            end else if (wb_adr_i == FRAME_RATE_ADDR) begin
                n.ps = wv[PS_LSB+:3];
                n.cd = wv[CD_LSB+:3];
            end else if (wb_adr_i == CONTRAST_ADDR) begin
                n.dt = wv[DT_LSB+:3];
                n.cc = wv[CC_LSB+:4];
            end else if (wb_adr_i == ASYNC_ADDR) begin
                n.external_clock_enable_bit = wv[EXTERNAL_CLOCK_ENABLE_BIT_BIT];
            end else if (wb_adr_i == POWER_ADDR) begin
                n.power_reduction_reg = wv[PRR_BIT];
            end else if (wb_adr_i >= MEM_BASE_ADDR && wb_adr_i <= MEM_LAST_ADDR && wb_adr_i[1:0] == 2'b00) begin
                n.mem[wb_adr_i[3:2]] = wv[SEG_COUNT-1:0];
            end
        end
        if (frame_flag_ack) begin
            n.flag = 1'b0;
        end

        active = q.en & ~q.power_reduction_reg;
        // sleep modes where the display keeps running; others freeze the scan
        case (sleep_mode)
            SLEEP_NONE:   run_ok = 1'b1;
            SLEEP_IDLE:   run_ok = 1'b1;
            SLEEP_PSAVE:  run_ok = 1'b1;
            SLEEP_ADC_NR: run_ok = q.cs & sys_clk_is_rc;
            default:      run_ok = 1'b0;
        endcase
        base_tick = run_ok & (q.cs ? osc_rise : 1'b1);

        // prescaler and fine divider
        ps_tick = 1'b0;
        tick    = 1'b0;
        if (base_tick) begin
            n.pre   = 12'(q.pre + 12'h001);
            ps_tick = (q.pre & PS_MASK[q.ps]) == PS_MASK[q.ps];
        end
        if (ps_tick) begin
            if (q.fine >= q.cd) begin
                n.fine = 3'h0;
                tick   = 1'b1;
            end else begin
                n.fine = 3'(q.fine + 3'h1);
            end
        end

        // frame and common sequencing, paced by tick except the first frame, which starts once the supply is ready
        case (q.state)
            ST_OFF: begin
                if (active) begin
                    n.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (q.rdy_s2) begin
                    fstart = 1'b1;
                end
            end
            default: begin
                if (tick) begin
                    n.half_ph = ~q.half_ph;
                    // two half slots per common, same for every common
                    if (q.half_ph) begin
                        if (q.com >= q.duty) begin
                            fstart = 1'b1;
                        end else begin
                            n.com = 2'(q.com + 2'h1);
                        end
                    end
                end
            end
        endcase

        if (fstart) begin
            n.com       = 2'h0;
            n.half_ph   = 1'b0;
            n.frame_pol = ~q.frame_pol;
            if (!q.repeat_frame) begin
                n.lat          = q.mem;
                n.lat_lpw      = q.lpw;
                n.lat_blank    = q.blank;
                n.lat_cc       = q.cc;
                n.repeat_frame = q.lpw;
                n.flag         = 1'b1;
            end else begin
                n.repeat_frame = 1'b0;
            end
            n.state = n.lat_blank ? ST_BLANK : ST_RUN;
        end

        // disable wins immediately over the state and counters set above
        if (!active) begin
            n.state        = ST_OFF;
            n.com          = 2'h0;
            n.half_ph      = 1'b0;
            n.repeat_frame = 1'b0;
            n.pre          = 12'h000;
            n.fine         = 3'h0;
            n.drv_cnt      = 16'h0000;
        end

        // intermediate buffers run for the drive time at each half slot
        if (n.state != ST_RUN) begin
            n.drv_cnt = 16'h0000;
        end else if (tick || fstart) begin
            n.drv_cnt = 16'((16'(q.dt) + 16'h0001) * 16'(DRIVE_STEP));
        end else if (q.drv_cnt != 16'h0000) begin
            n.drv_cnt = 16'(q.drv_cnt - 16'h0001);
        end

        // low-power waveform flips once per frame, default flips every half slot within a frame
        pol  = n.lat_lpw ? n.frame_pol : (n.frame_pol ^ n.half_ph);
        nseg = PM_SEGS[n.pm];
        for (int j = 0; j < SEG_COUNT; j++) begin
            n.seg_own[j] = (n.state != ST_OFF) && (5'(j) < nseg);
            n.seg_ph[j]  = (n.state == ST_RUN) && (n.lat[n.com][j] ? ~pol : pol);
        end
        for (int i = 0; i < COM_COUNT; i++) begin
            n.com_own[i]  = (n.state != ST_OFF) && (2'(i) <= n.duty);
            n.com_addr[i] = (n.state == ST_RUN) && (2'(i) == n.com);
            n.com_ph[i]   = (n.state == ST_RUN) && ((2'(i) == n.com) ? pol : ~pol);
        end
        // pins stay undriven until the supply is up; blanking drives ground
        n.oe     = (n.state == ST_BLANK) || (n.state == ST_RUN && n.drv_cnt != 16'h0000);
        n.gnd    = (n.state == ST_BLANK);
        n.buf_en = (n.state == ST_RUN) && (n.drv_cnt != 16'h0000) && (n.duty != 2'h0);
        n.bias   = (n.duty == 2'h0) ? 2'h0 : (n.half ? 2'h1 : 2'h2);
        n.ext_buf = n.cs & n.external_clock_enable_bit;
        n.xtal    = n.cs & ~n.external_clock_enable_bit;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign wb_dat_o               = q.dat;
    assign wb_ack_o               = q.ack;
    assign frame_flag             = q.flag;
    assign segment_terminal_phase = q.seg_ph;
    assign segment_terminal_own   = q.seg_own;
    assign common_terminal_phase  = q.com_ph;
    assign common_terminal_addr   = q.com_addr;
    assign common_terminal_own    = q.com_own;
    assign pins_oe                = q.oe;
    assign ground_all             = q.gnd;
    assign bias_buffer_en         = q.buf_en;
    assign bias_mode              = q.bias;
    assign contrast_level         = q.lat_cc;
    assign ext_clock_buffer_en    = q.ext_buf;
    assign crystal_osc_en         = q.xtal;

endmodule

// [slf_glass_model.sv]
// passive glass model: records which segments see opposite phase per common
// assumes pad logic turns phase bits into glass voltages while pins_oe is high
`timescale 1ns/100ps
module slf_glass_model
    import slf_pkg::*;
(
    input  wire logic                              mclk,
    input  wire logic [SEG_COUNT-1:0]              segment_terminal_phase,
    input  wire logic [COM_COUNT-1:0]              common_terminal_phase,
    input  wire logic [COM_COUNT-1:0]              common_terminal_addr,
    input  wire logic                              pins_oe,
    output logic      [COM_COUNT-1:0][SEG_COUNT-1:0] lit
);
    // only a driven, addressed common can energize its row
    always @(posedge mclk) begin
        for (int k = 0; k < COM_COUNT; k++) begin
            if (pins_oe && common_terminal_addr[k])
                lit[k] <= segment_terminal_phase ^ {SEG_COUNT{common_terminal_phase[k]}};
        end
    end
endmodule

// [slf_frame_ctrl_chk.sv]
// port checker for the segment display frame controller
// assumes one mclk domain, resetn asynchronous and active low
`timescale 1ns/100ps
module slf_frame_ctrl_chk
    import slf_pkg::*;
#(
    parameter logic [11:0] DRIVE_STEP = DRIVE_STEP_CYC
) (
    input wire logic                 mclk,
    input wire logic                 resetn,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [7:0]           wb_adr_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    input wire logic                 supply_ready,
    input wire logic                 frame_flag,
    input wire logic [SEG_COUNT-1:0] segment_terminal_phase,
    input wire logic [COM_COUNT-1:0] common_terminal_phase,
    input wire logic [COM_COUNT-1:0] common_terminal_addr,
    input wire logic [COM_COUNT-1:0] common_terminal_own,
    input wire logic                 pins_oe,
    input wire logic                 ground_all,
    input wire logic                 bias_buffer_en,
    input wire logic [1:0]           bias_mode,
    input wire logic                 ext_clock_buffer_en,
    input wire logic                 crystal_osc_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_one_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_once: assert property (s_req |=> s_one_ack) else $error("bus answer not a single cycle");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h1c |-> wb_dat_o == '0)
        else $error("unmapped read not zero");
    a_supply_gate: assert property ($rose(pins_oe) |-> $past(supply_ready, 2)) else $error("drive before supply");
    a_blank_ground: assert property (ground_all |-> segment_terminal_phase == '0 && common_terminal_phase == '0)
        else $error("blanked terminals not grounded");
    a_addr_owned: assert property ((common_terminal_addr & ~common_terminal_own) == '0)
        else $error("unused common addressed");
    a_one_common: assert property ($onehot0(common_terminal_addr)) else $error("two commons addressed");
    a_bias_in_oe: assert property (bias_buffer_en |-> pins_oe) else $error("buffers on with pins released");
    a_bias_code: assert property (bias_mode != 2'd3) else $error("bad bias code");
    a_clock_excl: assert property (!(ext_clock_buffer_en && crystal_osc_en)) else $error("both clock inputs on");
    a_flag_frame: assert property ($rose(frame_flag) |-> ##[0:1] (common_terminal_addr == 4'h1 || ground_all))
        else $error("flag not at frame start");
endmodule
bind slf_frame_ctrl slf_frame_ctrl_chk #(.DRIVE_STEP(DRIVE_STEP)) u_chk (.mclk(mclk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .supply_ready(supply_ready), .frame_flag(frame_flag),
    .segment_terminal_phase(segment_terminal_phase), .common_terminal_phase(common_terminal_phase),
    .common_terminal_addr(common_terminal_addr), .common_terminal_own(common_terminal_own), .pins_oe(pins_oe),
    .ground_all(ground_all), .bias_buffer_en(bias_buffer_en), .bias_mode(bias_mode),
    .ext_clock_buffer_en(ext_clock_buffer_en), .crystal_osc_en(crystal_osc_en));

// [tb_top.sv]
// testbench: register tasks over classic wishbone, table of frame timing cases
// assumes DRIVE_STEP shortened to 2 cycles and a free-running pin oscillator
`timescale 1ns/100ps
module tb_top
    import slf_pkg::*;
;
    logic                              mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic                              timer_osc_input_pin, supply_ready, sys_clk_is_rc, frame_flag_ack;
    logic                              frame_flag, pins_oe, ground_all, bias_buffer_en, ext_en, xtal_en;
    logic [7:0]                        wb_adr_i;
    logic [3:0]                        wb_sel_i, com_ph, com_addr, com_own, contrast_level;
    logic [31:0]                       wb_dat_i, wb_dat_o, rd;
    logic [2:0]                        sleep_mode;
    logic [1:0]                        bias_mode;
    logic [SEG_COUNT-1:0]              seg_ph, seg_own;
    logic [COM_COUNT-1:0][SEG_COUNT-1:0] lit;
    int                                err_total, n_checks, n;
    // byte3 ctrl_b, byte2 frame rate, byte1 ctrl_a extra, bit5 rc, bit4 ext clk, bit3 power off, 2:0 sleep
    localparam logic [31:0] ROW [0:9] = '{32'h3701_0000, 32'h0010_0001, 32'h1307_0004, 32'h6702_0000,
        32'h3701_4000, 32'h8000_0003, 32'h3701_0008, 32'h8000_0010, 32'h8000_0022, 32'h8000_0002};
    localparam int GAP [0:9] = '{256, 128, 512, 288, 512, 0, 0, 192, 192, 0};
    localparam logic [24:0] MEM [0:3] = '{25'h1555555, 25'h0aaaaaa, 25'h1000001, 25'h0f0f0f0};
    slf_frame_ctrl #(.DRIVE_STEP(12'h002)) uut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_osc_input_pin(timer_osc_input_pin),
        .supply_ready(supply_ready), .sleep_mode(sleep_mode), .sys_clk_is_rc(sys_clk_is_rc),
        .frame_flag_ack(frame_flag_ack), .frame_flag(frame_flag), .segment_terminal_phase(seg_ph),
        .segment_terminal_own(seg_own), .common_terminal_phase(com_ph), .common_terminal_addr(com_addr),
        .common_terminal_own(com_own), .pins_oe(pins_oe), .ground_all(ground_all),
        .bias_buffer_en(bias_buffer_en), .bias_mode(bias_mode), .contrast_level(contrast_level),
        .ext_clock_buffer_en(ext_en), .crystal_osc_en(xtal_en));
    slf_glass_model glass (.mclk(mclk), .segment_terminal_phase(seg_ph), .common_terminal_phase(com_ph),
        .common_terminal_addr(com_addr), .pins_oe(pins_oe), .lit(lit));
    always #2 mclk = ~mclk;
    // pin oscillator period of 6 mclk cycles
    always #12 timer_osc_input_pin = ~timer_osc_input_pin;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until the rising edge that sees ack; data taken and request dropped there
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int t;
        t = 0;
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, s, d};
        do @(posedge mclk); while (wb_ack_o !== 1'b1 && ++t < 50);
        if (t >= 50) begin
            err_total++;
            $display("mismatch at %0t: no bus answer", $time);
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge mclk);
    endtask
    // cycles between two frame flag rises, 0 when none within bound
    task automatic frame_gap(output int g);
        int t;
        realtime ts [0:1];
        g = 0;
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            frame_flag_ack <= 1'b1;
            @(posedge mclk);
            frame_flag_ack <= 1'b0;
            // the clear lands on this edge; look only once it has settled
            @(negedge mclk);
            for (t = 0; t < 1500 && frame_flag !== 1'b1; t++) @(negedge mclk);
            if (t == 1500) return;
            ts[k] = $realtime;
        end
        g = int'((ts[1] - ts[0]) / 4.0);
    endtask
    task automatic run_row(input int i);
        logic [31:0] r;
        int          g;
        int          tol;
        r = ROW[i];
        tol = r[31] ? 2 : 0;
        wb(1, CTRL_A_ADDR, 32'h10, 4'hf);
        wb(1, POWER_ADDR, {27'h0, r[3], 4'h0}, 4'hf);
        wb(1, ASYNC_ADDR, {27'h0, r[4], 4'h0}, 4'hf);
        wb(1, CTRL_B_ADDR, {24'h0, r[31:24]}, 4'hf);
        wb(1, FRAME_RATE_ADDR, {24'h0, r[23:16]}, 4'hf);
        sleep_mode <= r[2:0];
        sys_clk_is_rc <= r[5];
        wb(1, CTRL_A_ADDR, {24'h0, r[15:8] | 8'h80}, 4'hf);
        frame_gap(g);
        chk((g >= GAP[i] - tol && g <= GAP[i] + tol) ? 32'(GAP[i]) : 32'(g), 32'(GAP[i]));
        if (GAP[i] == 0) return;
        chk({28'h0, com_own}, 32'((1 << (r[29:28] + 1)) - 1));
        chk({7'h0, seg_own}, 32'((33'h1 << PM_SEGS[r[26:24]]) - 1));
        chk({30'h0, bias_mode}, r[29:28] == 2'b00 ? 0 : (r[30] ? 1 : 2));
        if (r[31]) chk({30'h0, ext_en, xtal_en}, r[4] ? 2 : 1);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        end_sim;
    end
    initial begin
        {mclk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {timer_osc_input_pin, supply_ready, sys_clk_is_rc, frame_flag_ack, sleep_mode} = '0;
        {err_total, n_checks} = '0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        for (int a = 0; a < 12; a++) begin
            wb(0, 8'(a * 4), 32'h0, 4'hf);
            chk(rd, REG_RESET);
        end
        wb(1, 8'h1c, 32'hffff_ffff, 4'hf);
        wb(0, 8'h1c, 32'h0, 4'hf);
        chk(rd, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wb(1, MEM_BASE_ADDR + 8'(k * 4), {7'h7f, MEM[k]}, 4'hf);
            wb(0, MEM_BASE_ADDR + 8'(k * 4), 32'h0, 4'hf);
            chk(rd, {7'h0, MEM[k]});
        end
        wb(1, CONTRAST_ADDR, 32'h0f, 4'h0);
        wb(0, CONTRAST_ADDR, 32'h0, 4'hf);
        chk(rd, 32'h0);
        wb(1, CONTRAST_ADDR, 32'h0f, 4'h1);
        // supply still low: enabled display must stay inhibited
        wb(1, CTRL_A_ADDR, 32'h80, 4'hf);
        repeat (100) @(negedge mclk);
        chk({30'h0, pins_oe, frame_flag}, 32'h0);
        supply_ready <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            run_row(i);
            if (i == 0) begin
                chk({28'h0, contrast_level}, 32'hf);
                for (int k = 0; k < 4; k++) chk({7'h0, lit[k]}, {7'h0, MEM[k]});
            end
        end
        run_row(0);
        wb(1, CTRL_A_ADDR, 32'h91, 4'hf);
        frame_gap(n);
        chk({6'h0, ground_all, seg_ph}, 32'h0200_0000);
        wb(0, MEM_BASE_ADDR, 32'h0, 4'hf);
        chk(rd, {7'h0, MEM[0]});
        wb(1, CTRL_A_ADDR, 32'h0, 4'hf);
        @(negedge mclk);
        chk({2'b0, pins_oe, com_own, seg_own}, 32'h0);
        end_sim;
    end
endmodule
